/* File: hdl/acr_regs.sv */
// Control register bank of a quad converter, written over the serial port.
// Assumes serial port pins arrive synchronous to i_clk and slower than it.
`timescale 1ns/1ps
module acr_regs (
  // Clock and power-on reset.
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  // Serial control port.
  input  wire logic        i_sclk,
  input  wire logic        i_csb,
  input  wire logic        i_sdio,
  output logic             o_sdio,
  output logic             o_sdio_oe,
  // Device pins.
  input  wire logic        i_powerdown_pin,
  input  wire logic        i_no_serial_cfg,
  // Power control.
  output logic             o_dp_clk_en,
  output logic             o_dp_rst,
  output logic             o_out_en,
  // Converter and clock options.
  output logic             o_dcs_on,
  output logic             o_chop_en,
  output logic [2:0]       o_in_clk_delay,
  output logic [3:0]       o_out_clk_phase,
  // Per-channel output options.
  output logic [3:0]       o_reduced_range,
  output logic [3:0]       o_invert,
  output logic [3:0]       o_twos_comp,
  output logic [11:0]      o_term,
  output logic [1:0]       o_drive_2x,
  // Serial output data control.
  output logic             o_lsb_first,
  output logic [2:0]       o_lane_mode,
  output logic             o_frame_2x,
  output logic [1:0]       o_serial_bits,
  // Rate override and user pins.
  output logic             o_rate_en,
  output logic [2:0]       o_rate_sel,
  output logic             o_sdio_pd_on,
  output logic             o_vcm_pd
);

  ////////////////////////////////////////////////////////////////////////////
  // State.

  acr_pkg::acr_state_s s_q;
  acr_pkg::acr_state_s s_d;
  logic                rise;
  logic                fall;
  logic [7:0]          byte_in;
  logic [7:0]          wd;
  logic                wr_en;
  logic                commit_wr;

  assign rise      = i_sclk & ~s_q.sclk_prev;
  assign fall      = ~i_sclk & s_q.sclk_prev;
  assign byte_in   = {s_q.sr[6:0], i_sdio};
  assign wr_en     = ~i_csb & rise & (s_q.ph == acr_pkg::SP_DATA)
                   & (s_q.cnt == acr_pkg::BYTE_LAST) & ~s_q.rd;
  assign wd        = byte_in;
  assign commit_wr = wr_en & (s_q.addr == acr_pkg::OFS_COMMIT)
                   & wd[acr_pkg::BIT_COMMIT];

  // Per-channel registers read back the lowest selected channel.
  function automatic logic [7:0] rd_val(input acr_pkg::acr_state_s st,
                                        input acr_pkg::acr_addr_t  a);
    logic [1:0] cd;
    logic [2:0] cc;
    logic [7:0] v;
    cd = 2'h0;
    cc = 3'h0;
    for (int k = acr_pkg::N_DATA - 1; k >= 0; k--) begin
      if (st.index[k]) cd = 2'(k);
    end
    for (int k = acr_pkg::N_CHAN - 1; k >= 0; k--) begin
      if (st.index[k]) cc = 3'(k);
    end
    unique case (a)
      acr_pkg::OFS_INDEX:  v = st.index;
      acr_pkg::OFS_POWER:  v = st.power;
      acr_pkg::OFS_CLOCK:  v = st.clock;
      acr_pkg::OFS_ENH:    v = st.enh;
      acr_pkg::OFS_OMODE:  v = st.omode[cd];
      acr_pkg::OFS_OADJ:   v = st.oadj[cc];
      acr_pkg::OFS_PHASE:  v = st.phase;
      acr_pkg::OFS_SERIAL: v = st.serial;
      acr_pkg::OFS_RATE:   v = st.rate_pend;
      acr_pkg::OFS_PIN2:   v = st.pin2;
      acr_pkg::OFS_PIN3:   v = st.pin3;
      default:             v = 8'h00;
    endcase
    return v;
  endfunction : rd_val

  ////////////////////////////////////////////////////////////////////////////
  // Next state.

  always_comb begin
    acr_pkg::acr_pwr_e pm;
    s_d           = s_q;
    pm            = acr_pkg::PM_NORMAL;
    s_d.sclk_prev = i_sclk;
    // The serial port state answers to nothing but i_rst and chip select.
    if (i_csb) begin
      s_d.ph      = acr_pkg::SP_HEAD;
      s_d.cnt     = 4'h0;
      s_d.sdio_oe = 1'b0;
    end else if (rise) begin
      s_d.sr  = {s_q.sr[14:0], i_sdio};
      s_d.cnt = s_q.cnt + 4'h1;
      if (s_q.ph == acr_pkg::SP_HEAD && s_q.cnt == acr_pkg::HEAD_LAST) begin
        s_d.ph   = acr_pkg::SP_DATA;
        s_d.cnt  = 4'h0;
        s_d.rd   = s_q.sr[14];
        s_d.addr = {s_q.sr[11:0], i_sdio};
        s_d.osr  = rd_val(s_q, {s_q.sr[11:0], i_sdio});
      end else if (s_q.ph == acr_pkg::SP_DATA && s_q.cnt == acr_pkg::BYTE_LAST) begin
        // Streaming walks downward through the map.
        s_d.cnt  = 4'h0;
        s_d.addr = s_q.addr - 13'h1;
        s_d.osr  = rd_val(s_q, s_q.addr - 13'h1);
      end
    end else if (fall && s_q.ph == acr_pkg::SP_DATA && s_q.rd) begin
      s_d.sdio    = s_q.osr[7];
      s_d.osr     = {s_q.osr[6:0], 1'b0};
      s_d.sdio_oe = 1'b1;
    end

    // Register writes take effect on the last bit of the byte.
    if (wr_en) begin
      unique case (s_q.addr)
        acr_pkg::OFS_INDEX:  s_d.index  = wd & acr_pkg::MSK_INDEX;
        acr_pkg::OFS_POWER:  s_d.power  = wd & acr_pkg::MSK_POWER;
        acr_pkg::OFS_CLOCK:  s_d.clock  = wd & acr_pkg::MSK_CLOCK;
        acr_pkg::OFS_ENH:    s_d.enh    = wd & acr_pkg::MSK_ENH;
        acr_pkg::OFS_SERIAL: s_d.serial = wd & acr_pkg::MSK_SERIAL;
        acr_pkg::OFS_PIN2:   s_d.pin2   = wd & acr_pkg::MSK_PIN2;
        acr_pkg::OFS_PIN3:   s_d.pin3   = wd & acr_pkg::MSK_PIN3;
        acr_pkg::OFS_RATE:   s_d.rate_pend = wd & acr_pkg::MSK_RATE;
        acr_pkg::OFS_PHASE: begin
          s_d.phase[6:4] = wd[6:4];
          // Codes above the last step would be a phase the clock tree lacks.
          if (wd[3:0] <= acr_pkg::OCP_MAX) s_d.phase[3:0] = wd[3:0];
        end
        acr_pkg::OFS_OMODE: begin
          for (int k = 0; k < acr_pkg::N_DATA; k++) begin
            if (s_q.index[k]) s_d.omode[k] = wd & acr_pkg::MSK_OMODE;
          end
        end
        acr_pkg::OFS_OADJ: begin
          for (int k = 0; k < acr_pkg::N_CHAN; k++) begin
            if (s_q.index[k]) s_d.oadj[k] = wd & acr_pkg::MSK_OADJ;
          end
        end
        default: ;
      endcase
    end
    if (commit_wr) s_d.rate_act = s_q.rate_pend;

    // Effective power mode, with the pin overriding the field.
    pm = acr_pkg::acr_pwr_e'(s_q.power[1:0]);
    if (i_powerdown_pin) begin
      pm = s_q.power[acr_pkg::BIT_PIN_STBY] ? acr_pkg::PM_STANDBY
                                            : acr_pkg::PM_POWERDOWN;
    end
    unique case (pm)
      acr_pkg::PM_NORMAL: begin
        s_d.dp_clk_en = 1'b1;
        s_d.dp_rst    = 1'b0;
        s_d.out_en    = 1'b1;
      end
      acr_pkg::PM_POWERDOWN: begin
        s_d.dp_clk_en = 1'b0;
        s_d.dp_rst    = 1'b1;
        s_d.out_en    = 1'b0;
      end
      acr_pkg::PM_STANDBY: begin
        s_d.dp_clk_en = 1'b0;
        s_d.dp_rst    = 1'b0;
        s_d.out_en    = 1'b0;
      end
      acr_pkg::PM_DIGRESET: begin
        s_d.dp_clk_en = 1'b1;
        s_d.dp_rst    = 1'b1;
        s_d.out_en    = 1'b0;
      end
    endcase

    s_d.dcs_on     = i_no_serial_cfg | ~s_q.clock[acr_pkg::BIT_DCS];
    s_d.sdio_pd_on = ~s_q.pin2[acr_pkg::BIT_SDIO_PD];
    for (int k = 0; k < 2; k++) begin
      s_d.drive2x[k] = s_q.oadj[acr_pkg::N_DATA + k][acr_pkg::BIT_DRIVE]
                     & (s_q.oadj[acr_pkg::N_DATA + k][5:4] == 2'h0);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register.

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      s_q            <= '0;
      s_q.index      <= acr_pkg::RST_INDEX;
      s_q.power      <= acr_pkg::RST_POWER;
      s_q.clock      <= acr_pkg::RST_CLOCK;
      s_q.enh        <= acr_pkg::RST_ENH;
      s_q.phase      <= acr_pkg::RST_PHASE;
      s_q.serial     <= acr_pkg::RST_SERIAL;
      s_q.rate_pend  <= acr_pkg::RST_RATE;
      s_q.rate_act   <= acr_pkg::RST_RATE;
      s_q.pin2       <= acr_pkg::RST_PIN;
      s_q.pin3       <= acr_pkg::RST_PIN;
      s_q.omode      <= {acr_pkg::N_DATA{acr_pkg::RST_OMODE}};
      s_q.oadj       <= {acr_pkg::N_CHAN{acr_pkg::RST_OADJ}};
      s_q.dp_clk_en  <= 1'b1;
      s_q.out_en     <= 1'b1;
      s_q.sdio_pd_on <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all taken from state flip-flops.

  assign o_sdio          = s_q.sdio;
  assign o_sdio_oe       = s_q.sdio_oe;
  assign o_dp_clk_en     = s_q.dp_clk_en;
  assign o_dp_rst        = s_q.dp_rst;
  assign o_out_en        = s_q.out_en;
  assign o_dcs_on        = s_q.dcs_on;
  assign o_chop_en       = s_q.enh[acr_pkg::BIT_CHOP];
  assign o_in_clk_delay  = s_q.phase[acr_pkg::BIT_ICP +: 3];
  assign o_out_clk_phase = s_q.phase[acr_pkg::BIT_OCP +: 4];
  assign o_drive_2x      = s_q.drive2x;
  assign o_lsb_first     = s_q.serial[acr_pkg::BIT_LSB];
  assign o_lane_mode     = s_q.serial[acr_pkg::BIT_LANE +: 3];
  assign o_frame_2x      = s_q.serial[acr_pkg::BIT_FRAME];
  assign o_serial_bits   = s_q.serial[acr_pkg::BIT_SONB +: 2];
  assign o_rate_en       = s_q.rate_act[acr_pkg::BIT_RATE_EN];
  assign o_rate_sel      = s_q.rate_act[acr_pkg::BIT_RATE +: 3];
  assign o_sdio_pd_on    = s_q.sdio_pd_on;
  assign o_vcm_pd        = s_q.pin3[acr_pkg::BIT_VCM_PD];

  for (genvar g = 0; g < acr_pkg::N_CHAN; g++) begin : g_chan
    assign o_term[2*g +: 2] = s_q.oadj[g][acr_pkg::BIT_TERM +: 2];
    if (g < acr_pkg::N_DATA) begin : g_data
      assign o_reduced_range[g] = s_q.omode[g][acr_pkg::BIT_IEEE];
      assign o_invert[g]        = s_q.omode[g][acr_pkg::BIT_INVERT];
      assign o_twos_comp[g]     = s_q.omode[g][acr_pkg::BIT_TWOS];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions.

  sequence pin_stby_s;
    i_powerdown_pin && s_q.power[acr_pkg::BIT_PIN_STBY];
  endsequence

  sequence pin_powerdown_pin_s;
    i_powerdown_pin && !s_q.power[acr_pkg::BIT_PIN_STBY];
  endsequence

  commit_hold_a: assert property (@(posedge i_clk) disable iff (i_rst)
    !commit_wr |=> $stable(s_q.rate_act))
    else $error("rate override changed without a commit");
  commit_load_a: assert property (@(posedge i_clk) disable iff (i_rst)
    commit_wr |=> s_q.rate_act == $past(s_q.rate_pend))
    else $error("commit did not load the pending rate override");
  pin_standby_a: assert property (@(posedge i_clk) disable iff (i_rst)
    pin_stby_s |=> !o_dp_clk_en && !o_dp_rst && !o_out_en)
    else $error("pin with standby select did not enter standby");
  pin_powerdown_a: assert property (@(posedge i_clk) disable iff (i_rst)
    pin_powerdown_pin_s |=> !o_dp_clk_en && o_dp_rst && !o_out_en)
    else $error("pin did not enter power-down");
  normal_mode_a: assert property (@(posedge i_clk) disable iff (i_rst)
    !i_powerdown_pin && s_q.power[1:0] == 2'h0 |=> o_dp_clk_en && !o_dp_rst && o_out_en)
    else $error("normal mode did not keep the datapath running");
  digital_reset_a: assert property (@(posedge i_clk) disable iff (i_rst)
    !i_powerdown_pin && s_q.power[1:0] == 2'h3 |=> o_dp_rst && !o_out_en)
    else $error("digital reset mode did not reset the datapath");
  drive_term_a: assert property (@(posedge i_clk) disable iff (i_rst)
    o_drive_2x[0] |-> $past(s_q.oadj[acr_pkg::N_DATA][5:4]) == 2'h0)
    else $error("double drive active with a termination selected");
  write_now_a: assert property (@(posedge i_clk) disable iff (i_rst)
    wr_en && s_q.addr == acr_pkg::OFS_CLOCK |=> s_q.clock[0] == $past(wd[0]))
    else $error("clock register write did not take effect at once");
  open_bits_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (s_q.power & ~acr_pkg::MSK_POWER) == 8'h00)
    else $error("open power mode bits became set");

  // The serial port steps through header and bytes in every power mode, because
  // nothing but power-on reset and chip select may disturb it.
  sequence head_done_s;
    !i_csb && rise && s_q.ph == acr_pkg::SP_HEAD && s_q.cnt == acr_pkg::HEAD_LAST;
  endsequence

  sequence byte_done_s;
    !i_csb && rise && s_q.ph == acr_pkg::SP_DATA && s_q.cnt == acr_pkg::BYTE_LAST;
  endsequence

  head_to_data_a: assert property (@(posedge i_clk) disable iff (i_rst)
    head_done_s |=> s_q.ph == acr_pkg::SP_DATA && s_q.cnt == 4'h0)
    else $error("header end did not open the data phase");
  stream_step_a: assert property (@(posedge i_clk) disable iff (i_rst)
    byte_done_s |=> s_q.addr == $past(s_q.addr) - 13'h1)
    else $error("byte end did not step the address down");
  port_idle_a: assert property (@(posedge i_clk) disable iff (i_rst)
    i_csb |=> s_q.ph == acr_pkg::SP_HEAD && !o_sdio_oe)
    else $error("deselected port did not return to idle");
  reset_spares_a: assert property (@(posedge i_clk) disable iff (i_rst)
    o_dp_rst && !i_csb && rise && s_q.ph == acr_pkg::SP_HEAD
    |=> s_q.cnt == $past(s_q.cnt) + 4'h1)
    else $error("datapath reset disturbed the serial port");
  powerdown_mode_a: assert property (@(posedge i_clk) disable iff (i_rst)
    !i_powerdown_pin && s_q.power[1:0] == 2'h1 |=> !o_dp_clk_en && o_dp_rst && !o_out_en)
    else $error("power-down mode left the datapath running");
  standby_mode_a: assert property (@(posedge i_clk) disable iff (i_rst)
    !i_powerdown_pin && s_q.power[1:0] == 2'h2 |=> !o_dp_clk_en && !o_dp_rst && !o_out_en)
    else $error("standby mode left the datapath running");
  stabilizer_force_a: assert property (@(posedge i_clk) disable iff (i_rst)
    i_no_serial_cfg |=> o_dcs_on)
    else $error("stabilizer off without serial configuration");
  phase_range_a: assert property (@(posedge i_clk) disable iff (i_rst)
    o_out_clk_phase <= acr_pkg::OCP_MAX)
    else $error("output clock phase beyond the last step");
  omode_select_a: assert property (@(posedge i_clk) disable iff (i_rst)
    wr_en && s_q.addr == acr_pkg::OFS_OMODE && !s_q.index[0] |=> $stable(s_q.omode[0]))
    else $error("unselected channel took an output mode write");
  commit_bit_a: assert property (@(posedge i_clk) disable iff (i_rst)
    wr_en && s_q.addr == acr_pkg::OFS_COMMIT && !wd[acr_pkg::BIT_COMMIT]
    |=> $stable(s_q.rate_act))
    else $error("commit write with bit zero clear changed the rate");
  term_wins_a: assert property (@(posedge i_clk) disable iff (i_rst)
    s_q.oadj[acr_pkg::N_DATA + 1][5:4] != 2'h0 |=> !o_drive_2x[1])
    else $error("frame clock double drive beside a termination");
  pulldown_off_a: assert property (@(posedge i_clk) disable iff (i_rst)
    s_q.pin2[acr_pkg::BIT_SDIO_PD] |=> !o_sdio_pd_on)
    else $error("data pin pull-down stayed on");
  open_fields_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (s_q.serial & ~acr_pkg::MSK_SERIAL) == 8'h00 && (s_q.phase & ~acr_pkg::MSK_PHASE) == 8'h00
    && (s_q.rate_pend & ~acr_pkg::MSK_RATE) == 8'h00)
    else $error("open register bits became set");

endmodule : acr_regs

/* File: hdl/acr_pkg.sv */
// Shared constants and carriers of the converter control register bank.
// Assumes a single 100 MHz clock and a three-wire serial control port.
package acr_pkg;

  typedef logic [12:0] acr_addr_t;
  typedef logic [7:0]  acr_byte_t;

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets.
  localparam acr_addr_t OFS_INDEX  = 13'h005;
  localparam acr_addr_t OFS_POWER  = 13'h008;
  localparam acr_addr_t OFS_CLOCK  = 13'h009;
  localparam acr_addr_t OFS_ENH    = 13'h00C;
  localparam acr_addr_t OFS_OMODE  = 13'h014;
  localparam acr_addr_t OFS_OADJ   = 13'h015;
  localparam acr_addr_t OFS_PHASE  = 13'h016;
  localparam acr_addr_t OFS_SERIAL = 13'h021;
  localparam acr_addr_t OFS_COMMIT = 13'h0FF;
  localparam acr_addr_t OFS_RATE   = 13'h100;
  localparam acr_addr_t OFS_PIN2   = 13'h101;
  localparam acr_addr_t OFS_PIN3   = 13'h102;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values.
  localparam acr_byte_t RST_INDEX  = 8'h3F;
  localparam acr_byte_t RST_POWER  = 8'h00;
  localparam acr_byte_t RST_CLOCK  = 8'h01;
  localparam acr_byte_t RST_ENH    = 8'h00;
  localparam acr_byte_t RST_OMODE  = 8'h01;
  localparam acr_byte_t RST_OADJ   = 8'h00;
  localparam acr_byte_t RST_PHASE  = 8'h03;
  localparam acr_byte_t RST_SERIAL = 8'h30;
  localparam acr_byte_t RST_RATE   = 8'h00;
  localparam acr_byte_t RST_PIN    = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Writable bits; open bits are dropped on write and read as zero.
  localparam acr_byte_t MSK_INDEX  = 8'h3F;
  localparam acr_byte_t MSK_POWER  = 8'h23;
  localparam acr_byte_t MSK_CLOCK  = 8'h01;
  localparam acr_byte_t MSK_ENH    = 8'h04;
  localparam acr_byte_t MSK_OMODE  = 8'h45;
  localparam acr_byte_t MSK_OADJ   = 8'h31;
  localparam acr_byte_t MSK_PHASE  = 8'h7F;
  localparam acr_byte_t MSK_SERIAL = 8'hF7;
  localparam acr_byte_t MSK_RATE   = 8'h47;
  localparam acr_byte_t MSK_PIN2   = 8'h01;
  localparam acr_byte_t MSK_PIN3   = 8'h08;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions.
  localparam int BIT_PIN_STBY = 5;
  localparam int BIT_DCS      = 0;
  localparam int BIT_CHOP     = 2;
  localparam int BIT_IEEE     = 6;
  localparam int BIT_INVERT   = 2;
  localparam int BIT_TWOS     = 0;
  localparam int BIT_DRIVE    = 0;
  localparam int BIT_TERM     = 4;
  localparam int BIT_ICP      = 4;
  localparam int BIT_OCP      = 0;
  localparam int BIT_LANE     = 4;
  localparam int BIT_LSB      = 7;
  localparam int BIT_FRAME    = 2;
  localparam int BIT_SONB     = 0;
  localparam int BIT_RATE_EN  = 6;
  localparam int BIT_RATE     = 0;
  localparam int BIT_COMMIT   = 0;
  localparam int BIT_SDIO_PD  = 0;
  localparam int BIT_VCM_PD   = 3;
  localparam logic [3:0] OCP_MAX = 4'hB;
  localparam logic [3:0] HEAD_LAST = 4'hF;
  localparam logic [3:0] BYTE_LAST = 4'h7;
  localparam int N_DATA = 4;
  localparam int N_CHAN = 6;

  typedef enum logic [1:0] {PM_NORMAL, PM_POWERDOWN, PM_STANDBY, PM_DIGRESET} acr_pwr_e;
  typedef enum logic {SP_HEAD, SP_DATA} acr_phase_e;

  typedef struct packed {
    logic                     sclk_prev;
    acr_phase_e               ph;
    logic [3:0]               cnt;
    logic                     rd;
    acr_addr_t                addr;
    logic [15:0]              sr;
    acr_byte_t                osr;
    logic                     sdio;
    logic                     sdio_oe;
    acr_byte_t                index;
    acr_byte_t                power;
    acr_byte_t                clock;
    acr_byte_t                enh;
    acr_byte_t                phase;
    acr_byte_t                serial;
    acr_byte_t                rate_pend;
    acr_byte_t                rate_act;
    acr_byte_t                pin2;
    acr_byte_t                pin3;
    logic [N_DATA-1:0][7:0]   omode;
    logic [N_CHAN-1:0][7:0]   oadj;
    logic                     dp_clk_en;
    logic                     dp_rst;
    logic                     out_en;
    logic                     dcs_on;
    logic                     sdio_pd_on;
    logic [1:0]               drive2x;
  } acr_state_s;

endpackage : acr_pkg

/* File: verif/acr_host.sv */
// Host model that drives the serial control port of the register bank.
// Assumes i_clk is the bank's clock; the serial clock runs at a fifth of it.
`timescale 1ns/1ps
module acr_host (
  // Clock.
  input  wire logic i_clk,
  // Device side of the data pin.
  input  wire logic i_dev_sdio,
  input  wire logic i_dev_oe,
  input  wire logic i_pd_on,
  // Serial port lines.
  output logic      o_sclk,
  output logic      o_csb,
  output logic      o_sdio
);
  logic drv_q;
  logic bit_q;
  logic last_q;

  initial begin
    o_sclk = 1'b0;
    o_csb  = 1'b1;
    drv_q  = 1'b0;
    bit_q  = 1'b0;
    last_q = 1'b0;
  end

  // A released line falls to the pull-down, or else shows the inverse of
  // its last level, so a stale bit can never pass for read data.
  assign o_sdio = i_dev_oe ? i_dev_sdio : drv_q ? bit_q : i_pd_on ? 1'b0 : ~last_q;

  always @(posedge i_clk) begin
    last_q <= o_sdio;
  end

  ////////////////////////////////////////////////////////////////////////////
  // One transfer of a 16-bit header and one byte, MSB first.
  task automatic xfer(input logic rd, input logic [12:0] a, input logic [7:0] w,
                      output logic [7:0] r);
    logic [23:0] f;
    f = {rd, 2'h0, a, w};
    r = 8'h00;
    @(posedge i_clk);
    o_csb <= 1'b0;
    for (int k = 23; k >= 0; k--) begin
      o_sclk <= 1'b0;
      drv_q  <= !(rd && k < 8);
      bit_q  <= f[k];
      repeat (3) @(posedge i_clk);
      if (k < 8) begin
        r[k] = o_sdio;
      end
      o_sclk <= 1'b1;
      repeat (2) @(posedge i_clk);
    end
    o_sclk <= 1'b0;
    o_csb  <= 1'b1;
    drv_q  <= 1'b0;
    repeat (3) @(posedge i_clk);
  endtask : xfer
endmodule : acr_host

/* File: verif/acr_regs_bench.sv */
// Self-checking bench of the converter control register bank.
// Assumes the host model acr_host drives every serial port transfer.
`timescale 1ns/1ps
module acr_regs_bench;
  logic        i_clk;
  logic        i_rst;
  logic        i_powerdown_pin;
  logic        i_no_serial_cfg;
  logic        sclk, csb, line, dev_sdio, dev_oe, pd_on;
  logic        clk_en, dp_rst, out_en, dcs_on, chop, rate_en, vcm_pd, lsb, frame2x;
  logic [2:0]  in_dly, lane, rate_sel;
  logic [3:0]  phase, reduced, invert, twos;
  logic [11:0] term;
  logic [1:0]  drive2x, sbits;
  int          mismatches = 0;
  int          checks = 0;
  int          cycles = 0;

  acr_regs uut (.i_clk(i_clk), .i_rst(i_rst), .i_sclk(sclk), .i_csb(csb),
    .i_sdio(line), .o_sdio(dev_sdio), .o_sdio_oe(dev_oe),
    .i_powerdown_pin(i_powerdown_pin), .i_no_serial_cfg(i_no_serial_cfg),
    .o_dp_clk_en(clk_en), .o_dp_rst(dp_rst), .o_out_en(out_en), .o_dcs_on(dcs_on),
    .o_chop_en(chop), .o_in_clk_delay(in_dly), .o_out_clk_phase(phase),
    .o_reduced_range(reduced), .o_invert(invert), .o_twos_comp(twos), .o_term(term),
    .o_drive_2x(drive2x), .o_lsb_first(lsb), .o_lane_mode(lane), .o_frame_2x(frame2x),
    .o_serial_bits(sbits), .o_rate_en(rate_en), .o_rate_sel(rate_sel),
    .o_sdio_pd_on(pd_on), .o_vcm_pd(vcm_pd));

  acr_host host (.i_clk(i_clk), .i_dev_sdio(dev_sdio), .i_dev_oe(dev_oe),
    .i_pd_on(pd_on), .o_sclk(sclk), .o_csb(csb), .o_sdio(line));

  ////////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    checks++;
    if (s !== e) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  task automatic wr(input acr_pkg::acr_addr_t a, input acr_pkg::acr_byte_t d);
    acr_pkg::acr_byte_t r;
    host.xfer(1'b0, a, d, r);
  endtask : wr

  task automatic rchk(input acr_pkg::acr_addr_t a, input acr_pkg::acr_byte_t e);
    acr_pkg::acr_byte_t r;
    host.xfer(1'b1, a, 8'h00, r);
    chk($sformatf("register %h", a), r, e);
  endtask : rchk

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rchk(acr_pkg::OFS_INDEX, 8'h3F);
    rchk(acr_pkg::OFS_CLOCK, 8'h01);
    rchk(acr_pkg::OFS_OMODE, 8'h01);
    rchk(acr_pkg::OFS_PHASE, 8'h03);
    rchk(acr_pkg::OFS_SERIAL, 8'h30);
    chk("stabilizer", dcs_on, 1'h0);
    chk("twos", twos, 4'hF);
    chk("range", reduced, 4'h0);
    chk("in delay", in_dly, 3'h0);
    chk("pull-down", pd_on, 1'h1);
    chk("power", {clk_en, dp_rst, out_en}, 3'h5);
    $display("reset test done");
  endtask : t_reset

  task automatic t_power();
    logic [2:0] exp [4] = '{3'h5, 3'h2, 3'h0, 3'h6};
    for (int m = 0; m < 4; m++) begin
      wr(acr_pkg::OFS_POWER, 8'(m));
      chk("power", {clk_en, dp_rst, out_en}, exp[m]);
    end
    // The port must still answer while the datapath sits in reset.
    rchk(acr_pkg::OFS_POWER, 8'h03);
    for (int s = 0; s < 2; s++) begin
      wr(acr_pkg::OFS_POWER, s ? 8'h20 : 8'h00);
      i_powerdown_pin <= 1'b1;
      repeat (3) @(posedge i_clk);
      chk("pin mode", {clk_en, dp_rst, out_en}, s ? 3'h0 : 3'h2);
      i_powerdown_pin <= 1'b0;
    end
    wr(acr_pkg::OFS_POWER, 8'h00);
    $display("power test done");
  endtask : t_power

  task automatic t_chan();
    wr(acr_pkg::OFS_INDEX, 8'h01);
    wr(acr_pkg::OFS_OMODE, 8'hFF);
    chk("range", reduced, 4'h1);
    chk("invert", invert, 4'h1);
    rchk(acr_pkg::OFS_OMODE, 8'h45);
    wr(acr_pkg::OFS_INDEX, 8'h02);
    wr(acr_pkg::OFS_OMODE, 8'h00);
    chk("twos", twos, 4'hD);
    rchk(acr_pkg::OFS_OMODE, 8'h00);
    $display("channel test done");
  endtask : t_chan

  task automatic t_drive();
    wr(acr_pkg::OFS_INDEX, 8'h30);
    wr(acr_pkg::OFS_OADJ, 8'h01);
    chk("drive", drive2x, 2'h3);
    wr(acr_pkg::OFS_OADJ, 8'h21);
    chk("term", term, 12'hA00);
    chk("drive", drive2x, 2'h0);
    $display("drive test done");
  endtask : t_drive

  task automatic t_misc();
    wr(13'h00A, 8'hFF);
    chk("chop", chop, 1'h0);
    wr(acr_pkg::OFS_ENH, 8'h04);
    chk("chop", chop, 1'h1);
    wr(acr_pkg::OFS_CLOCK, 8'h00);
    chk("stabilizer", dcs_on, 1'h1);
    wr(acr_pkg::OFS_CLOCK, 8'h01);
    chk("stabilizer", dcs_on, 1'h0);
    i_no_serial_cfg <= 1'b1;
    repeat (3) @(posedge i_clk);
    chk("stabilizer", dcs_on, 1'h1);
    i_no_serial_cfg <= 1'b0;
    wr(acr_pkg::OFS_PHASE, 8'h7B);
    chk("in delay", in_dly, 3'h7);
    chk("out phase", phase, 4'hB);
    wr(acr_pkg::OFS_PHASE, 8'h0C);
    chk("out phase", phase, 4'hB);
    chk("in delay", in_dly, 3'h0);
    wr(acr_pkg::OFS_RATE, 8'h45);
    chk("rate en", rate_en, 1'h0);
    rchk(acr_pkg::OFS_RATE, 8'h45);
    wr(acr_pkg::OFS_COMMIT, 8'h00);
    chk("rate en", rate_en, 1'h0);
    wr(acr_pkg::OFS_COMMIT, 8'h01);
    chk("rate en", rate_en, 1'h1);
    chk("rate sel", rate_sel, 3'h5);
    wr(acr_pkg::OFS_PIN2, 8'hFF);
    chk("pull-down", pd_on, 1'h0);
    wr(acr_pkg::OFS_PIN3, 8'h08);
    chk("reference", vcm_pd, 1'h1);
    for (int m = 0; m < 5; m++) begin
      wr(acr_pkg::OFS_SERIAL, {1'b0, 3'(m), 4'h0});
      chk("lane", lane, 16'(m));
    end
    wr(acr_pkg::OFS_SERIAL, 8'h8F);
    rchk(acr_pkg::OFS_SERIAL, 8'h87);
    chk("serial", {lsb, lane, frame2x, sbits}, 7'h47);
    $display("option test done");
  endtask : t_misc

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  // Each transfer takes 124 cycles; the ceiling leaves ample margin.
  always @(posedge i_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      stop_test();
    end
  end

  initial begin
    i_rst = 1'b1;
    i_powerdown_pin = 1'b0;
    i_no_serial_cfg = 1'b0;
    repeat (3) @(posedge i_clk);
    i_rst <= 1'b0;
    @(posedge i_clk);
    t_reset();
    t_power();
    t_chan();
    t_drive();
    t_misc();
    stop_test();
  end
endmodule : acr_regs_bench
